/* rtl/sfs_cfg.svh */
// register addresses, field positions, reset values and counts of the synthesizer control
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH

// ==========================================================
// serial word framing
`define SFS_WORD_BITS 28
`define SFS_ADDR_BITS 4
`define SFS_DATA_BITS 24

// ==========================================================
// register addresses
`define SFS_ADDR_FREQ 4'h0
`define SFS_ADDR_PUMP 4'h1
`define SFS_ADDR_MOD 4'h3
`define SFS_ADDR_TIMEOUT 4'h4
`define SFS_ADDR_POWER 4'h5
`define SFS_ADDR_FILTER 4'h6

// ==========================================================
// pump register fields
`define SFS_NUM_HI_LSB 0
`define SFS_NUM_HI_MSB 9
`define SFS_ICP_LSB 10
`define SFS_ICP_MSB 13

// ==========================================================
// modulator register fields
`define SFS_DEN_HI_LSB 0
`define SFS_DEN_HI_MSB 9
`define SFS_ORDER_LSB 10
`define SFS_ORDER_MSB 11
`define SFS_DITHER_LSB 12
`define SFS_DITHER_MSB 13
`define SFS_FDM_BIT 14
`define SFS_HALVE_BIT 15

// ==========================================================
// timeout register fields
`define SFS_TOC_LSB 0
`define SFS_TOC_MSB 13
`define SFS_SETTLE_PUMP_CURRENT_LSB 14
`define SFS_SETTLE_PUMP_CURRENT_MSB 17

// ==========================================================
// power register fields
`define SFS_EN_PLL_BIT 0
`define SFS_OSC_CORE_POWER_ENABLE_BIT 1
`define SFS_REF_INVERTER_POWER_ENABLE_BIT 2
`define SFS_OSC_REGULATOR_ENABLE_BIT 3
`define SFS_EN_LDO_A_BIT 4
`define SFS_EN_LDO_B_BIT 5
`define SFS_DIGITAL_REGULATOR_ENABLE_BIT 6
`define SFS_REG_RST_BIT 7

// ==========================================================
// filter register fields
`define SFS_CAP_LSB 0
`define SFS_CAP_MSB 2
`define SFS_RA_FL_LSB 3
`define SFS_RA_FL_MSB 4
`define SFS_RA_LSB 5
`define SFS_RA_MSB 6
`define SFS_RB_FL_LSB 7
`define SFS_RB_FL_MSB 8
`define SFS_RB_LSB 9
`define SFS_RB_MSB 10

// ==========================================================
// reset values
`define SFS_RST_PUMP 24'h000000
`define SFS_RST_MOD 24'h000000
`define SFS_RST_TIMEOUT 24'h000000
`define SFS_RST_POWER 24'h000000
`define SFS_RST_FILTER 24'h000000

// ==========================================================
// codes and counts
`define SFS_ORDER_FOURTH 2'h0
`define SFS_ORDER_INTEGER 2'h1
`define SFS_ORDER_SECOND 2'h2
`define SFS_ORDER_THIRD 2'h3
`define SFS_DITHER_WEAK 2'h0
`define SFS_DITHER_STRONG 2'h2
`define SFS_TOC_HIZ 14'h0000
`define SFS_TOC_ALWAYS 14'h0001
`define SFS_TOC_LOW 14'h0002
`define SFS_TOC_HIGH 14'h0003
`define SFS_TOC_MIN_TIMED 14'h0004
`define SFS_PD_CYCLES_PER_COUNT 2
`define SFS_CNT_BITS 15
`define SFS_RES_STEP_KOHM 6'h0a

`endif

/* rtl/sfs_pkg.sv */
// types shared by the synthesizer control logic
package sfs_pkg;
	typedef logic [23:0] sfs_word_t;
	typedef logic [3:0] sfs_addr_t;
	typedef enum logic [1:0] {
		SFS_STEADY = 2'b01,
		SFS_SETTLE = 2'b10
	} sfs_settle_t;
endpackage : sfs_pkg

/* rtl/sfs_synth_config_fast_settle_ctrl.sv */
// serial-programmed configuration and fast-settle control of a fractional-N synthesizer
//
// What this block does
// - modulator order code 0 fourth, 2 second, 3 third
// - order code 1 resets modulator, integer mode, fractions ignored
// - dither code 0 weak, 2 strong, 3 off; 1 reserved
// - extended fraction bit set uses upper ten fraction bits, else ignored
// - output halve bit divides oscillator output by two
// - timeout count 3 or less disables timing; pin is plain output
// - counts 0..3 give pin hi-z, low always settling, low, high
// - counts 4..16383 settle for count times two detector cycles
// - while settling pin grounded, settle pump current and settle resistors
// - steady state pin hi-z, normal pump current and resistor codes
// - settle pump code n gives n+1 unit current steps
// - loop power enable bit powers loop section
// - oscillator core enable bit powers the oscillator
// - reference inverter enable bit powers reference inverter
// - four regulator enable bits each power their regulator
// - register reset bit restores defaults and powers everything down
// - capacitor code decodes to two filter capacitor values
// - both first resistor codes select 10 to 40 kilohms
// - second resistor settle code selects 10 to 40 kilohms
// - second resistor normal code selects 10 to 40 kilohms
// - extended fraction bit clear ignores upper denominator bits
`timescale 1ns/1ns
`include "sfs_cfg.svh"

module sfs_synth_config_fast_settle_ctrl (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ser_clk_in,
	input wire logic ser_data_in,
	input wire logic ser_latch_in,
	input wire logic pd_clk_in,
	output logic [2:0] mod_order_out,
	output logic mod_reset_out,
	output logic dither_weak_out,
	output logic dither_strong_out,
	output logic [9:0] num_hi_out,
	output logic [9:0] den_hi_out,
	output logic output_halve_out,
	output logic settle_pin_out,
	output logic settle_pin_oe_out,
	output logic settle_active_out,
	output logic [4:0] pump_mult_out,
	output logic [5:0] res_a_kohm_out,
	output logic [5:0] res_b_kohm_out,
	output logic [7:0] cap_a_pf_out,
	output logic [7:0] cap_b_pf_out,
	output logic pll_power_out,
	output logic osc_core_power_enable_out,
	output logic ref_inverter_power_enable_out,
	output logic osc_regulator_enable_out,
	output logic loop_regulator_a_enable_out,
	output logic loop_regulator_b_enable_out,
	output logic digital_regulator_enable_out
);
	import sfs_pkg::*;

	// ==========================================================
	// link side: shift register on the serial clock
	logic [`SFS_WORD_BITS-1:0] shift_r;

	always_ff @(posedge ser_clk_in) begin
		shift_r <= {shift_r[`SFS_WORD_BITS-2:0], ser_data_in};
	end

	// ==========================================================
	// crossings into the core clock
	// the shift register is quiet while latch is high, so it is sampled on the latch edge
	logic le_s1_r;
	logic le_s2_r;
	logic le_s3_r;
	logic pd_s1_r;
	logic pd_s2_r;
	logic pd_s3_r;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			le_s1_r <= 1'b0;
			le_s2_r <= 1'b0;
			le_s3_r <= 1'b0;
			pd_s1_r <= 1'b0;
			pd_s2_r <= 1'b0;
			pd_s3_r <= 1'b0;
		end else begin
			le_s1_r <= ser_latch_in;
			le_s2_r <= le_s1_r;
			le_s3_r <= le_s2_r;
			pd_s1_r <= pd_clk_in;
			pd_s2_r <= pd_s1_r;
			pd_s3_r <= pd_s2_r;
		end
	end

	wire word_load = le_s2_r & ~le_s3_r;
	wire pd_tick = pd_s2_r & ~pd_s3_r;
	wire sfs_addr_t word_addr = shift_r[`SFS_ADDR_BITS-1:0];
	wire sfs_word_t word_data = shift_r[`SFS_WORD_BITS-1:`SFS_ADDR_BITS];

	// ==========================================================
	// register file
	sfs_word_t pump_reg_r;
	sfs_word_t mod_reg_r;
	sfs_word_t fast_settle_timeout_cfg_r;
	sfs_word_t power_enable_ctrl_r;
	sfs_word_t loop_filter_cfg_r;

	wire wr_freq = word_load & (word_addr == `SFS_ADDR_FREQ);
	wire wr_pump = word_load & (word_addr == `SFS_ADDR_PUMP);
	wire wr_mod = word_load & (word_addr == `SFS_ADDR_MOD);
	wire wr_timeout = word_load & (word_addr == `SFS_ADDR_TIMEOUT);
	wire wr_power = word_load & (word_addr == `SFS_ADDR_POWER);
	wire wr_filter = word_load & (word_addr == `SFS_ADDR_FILTER);
	wire reg_reset = wr_power & word_data[`SFS_REG_RST_BIT];

	always_ff @(posedge clk_in) begin
		if (srst_in || reg_reset) begin
			pump_reg_r <= `SFS_RST_PUMP;
			mod_reg_r <= `SFS_RST_MOD;
			fast_settle_timeout_cfg_r <= `SFS_RST_TIMEOUT;
			loop_filter_cfg_r <= `SFS_RST_FILTER;
		end else begin
			if (wr_pump) begin
				pump_reg_r <= word_data;
			end
			if (wr_mod) begin
				mod_reg_r <= word_data;
			end
			if (wr_timeout) begin
				fast_settle_timeout_cfg_r <= word_data;
			end
			if (wr_filter) begin
				loop_filter_cfg_r <= word_data;
			end
		end
	end

	// the reset bit itself is kept so the part stays down until released
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			power_enable_ctrl_r <= `SFS_RST_POWER;
		end else if (reg_reset) begin
			power_enable_ctrl_r <= `SFS_RST_POWER | (24'h000001 << `SFS_REG_RST_BIT);
		end else if (wr_power) begin
			power_enable_ctrl_r <= word_data;
		end
	end

	// ==========================================================
	// field extraction
	wire [1:0] order_code = mod_reg_r[`SFS_ORDER_MSB:`SFS_ORDER_LSB];
	wire [1:0] dither_code = mod_reg_r[`SFS_DITHER_MSB:`SFS_DITHER_LSB];
	wire extended_fraction_mode = mod_reg_r[`SFS_FDM_BIT];
	wire [13:0] settle_timeout_count = fast_settle_timeout_cfg_r[`SFS_TOC_MSB:`SFS_TOC_LSB];
	wire [3:0] pump_current = pump_reg_r[`SFS_ICP_MSB:`SFS_ICP_LSB];
	wire [3:0] settle_pump_current = fast_settle_timeout_cfg_r[`SFS_SETTLE_PUMP_CURRENT_MSB:`SFS_SETTLE_PUMP_CURRENT_LSB];
	wire [1:0] ra_code = loop_filter_cfg_r[`SFS_RA_MSB:`SFS_RA_LSB];
	wire [1:0] ra_fl_code = loop_filter_cfg_r[`SFS_RA_FL_MSB:`SFS_RA_FL_LSB];
	wire [1:0] rb_code = loop_filter_cfg_r[`SFS_RB_MSB:`SFS_RB_LSB];
	wire [1:0] rb_fl_code = loop_filter_cfg_r[`SFS_RB_FL_MSB:`SFS_RB_FL_LSB];
	wire [2:0] cap_code = loop_filter_cfg_r[`SFS_CAP_MSB:`SFS_CAP_LSB];
	wire pwr_hold = power_enable_ctrl_r[`SFS_REG_RST_BIT];

	// ==========================================================
	// fast-settle timeout counter, counted in detector cycles
	sfs_settle_t state_r;
	sfs_settle_t state_nxt;
	logic [`SFS_CNT_BITS-1:0] cnt_r;
	logic [`SFS_CNT_BITS-1:0] cnt_nxt;

	wire timed_mode = (settle_timeout_count >= `SFS_TOC_MIN_TIMED);
	wire [`SFS_CNT_BITS-1:0] cnt_load = `SFS_CNT_BITS'(settle_timeout_count * `SFS_PD_CYCLES_PER_COUNT);

	always_comb begin
		cnt_nxt = cnt_r;
		if (reg_reset || !timed_mode) begin
			cnt_nxt = '0;
		end else if (wr_freq) begin
			cnt_nxt = cnt_load;
		end else if (pd_tick && cnt_r != '0) begin
			cnt_nxt = cnt_r - `SFS_CNT_BITS'(1);
		end
	end

	assign state_nxt = (cnt_nxt != '0) ? SFS_SETTLE : SFS_STEADY;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cnt_r <= '0;
			state_r <= SFS_STEADY;
		end else begin
			cnt_r <= cnt_nxt;
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// decodes
	function automatic logic [5:0] res_kohm(input logic [1:0] code);
		res_kohm = 6'(({4'h0, code} + 6'h01) * `SFS_RES_STEP_KOHM);
	endfunction : res_kohm

	wire settling = (settle_timeout_count == `SFS_TOC_ALWAYS) || (state_r == SFS_SETTLE);
	wire int_mode = (order_code == `SFS_ORDER_INTEGER);
	wire [1:0] res_a_sel = settling ? ra_fl_code : ra_code;
	wire [1:0] res_b_sel = settling ? rb_fl_code : rb_code;
	wire [3:0] pump_sel = settling ? settle_pump_current : pump_current;

	logic [2:0] order_nxt;
	logic pin_nxt;
	logic pin_oe_nxt;
	logic [7:0] cap_a_nxt;
	logic [7:0] cap_b_nxt;

	always_comb begin
		unique case (order_code)
			`SFS_ORDER_FOURTH: order_nxt = 3'h4;
			`SFS_ORDER_SECOND: order_nxt = 3'h2;
			`SFS_ORDER_THIRD: order_nxt = 3'h3;
			default: order_nxt = 3'h0;
		endcase
	end

	always_comb begin
		pin_nxt = 1'b0;
		pin_oe_nxt = 1'b0;
		if (timed_mode) begin
			pin_oe_nxt = (state_r == SFS_SETTLE);
		end else begin
			unique case (settle_timeout_count)
				`SFS_TOC_ALWAYS: pin_oe_nxt = 1'b1;
				`SFS_TOC_LOW: pin_oe_nxt = 1'b1;
				`SFS_TOC_HIGH: begin
					pin_oe_nxt = 1'b1;
					pin_nxt = 1'b1;
				end
				default: pin_oe_nxt = 1'b0;
			endcase
		end
	end

	always_comb begin
		unique case (cap_code)
			3'h0: begin
				cap_a_nxt = 8'h32;
				cap_b_nxt = 8'h32;
			end
			3'h1: begin
				cap_a_nxt = 8'h32;
				cap_b_nxt = 8'h64;
			end
			3'h3: begin
				cap_a_nxt = 8'h64;
				cap_b_nxt = 8'h32;
			end
			3'h4: begin
				cap_a_nxt = 8'h96;
				cap_b_nxt = 8'h32;
			end
			3'h5: begin
				cap_a_nxt = 8'h64;
				cap_b_nxt = 8'h64;
			end
			default: begin
				cap_a_nxt = 8'h32;
				cap_b_nxt = 8'h96;
			end
		endcase
	end

	// ==========================================================
	// registered outputs
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mod_order_out <= 3'h0;
			mod_reset_out <= 1'b1;
			dither_weak_out <= 1'b0;
			dither_strong_out <= 1'b0;
			num_hi_out <= 10'h000;
			den_hi_out <= 10'h000;
			output_halve_out <= 1'b0;
			settle_pin_out <= 1'b0;
			settle_pin_oe_out <= 1'b0;
			settle_active_out <= 1'b0;
			pump_mult_out <= 5'h01;
			res_a_kohm_out <= `SFS_RES_STEP_KOHM;
			res_b_kohm_out <= `SFS_RES_STEP_KOHM;
			cap_a_pf_out <= 8'h32;
			cap_b_pf_out <= 8'h32;
		end else begin
			mod_order_out <= order_nxt;
			mod_reset_out <= int_mode;
			dither_weak_out <= (dither_code == `SFS_DITHER_WEAK);
			dither_strong_out <= (dither_code == `SFS_DITHER_STRONG);
			num_hi_out <= (extended_fraction_mode && !int_mode) ?
				pump_reg_r[`SFS_NUM_HI_MSB:`SFS_NUM_HI_LSB] : 10'h000;
			den_hi_out <= (extended_fraction_mode && !int_mode) ?
				mod_reg_r[`SFS_DEN_HI_MSB:`SFS_DEN_HI_LSB] : 10'h000;
			output_halve_out <= mod_reg_r[`SFS_HALVE_BIT];
			settle_pin_out <= pin_nxt;
			settle_pin_oe_out <= pin_oe_nxt;
			settle_active_out <= settling;
			pump_mult_out <= {1'b0, pump_sel} + 5'h01;
			res_a_kohm_out <= res_kohm(res_a_sel);
			res_b_kohm_out <= res_kohm(res_b_sel);
			cap_a_pf_out <= cap_a_nxt;
			cap_b_pf_out <= cap_b_nxt;
		end
	end

	// power enables are forced off while the reset bit is held
	always_comb begin
		pll_power_out = power_enable_ctrl_r[`SFS_EN_PLL_BIT] & ~pwr_hold;
		osc_core_power_enable_out = power_enable_ctrl_r[`SFS_OSC_CORE_POWER_ENABLE_BIT] & ~pwr_hold;
		ref_inverter_power_enable_out = power_enable_ctrl_r[`SFS_REF_INVERTER_POWER_ENABLE_BIT] & ~pwr_hold;
		osc_regulator_enable_out = power_enable_ctrl_r[`SFS_OSC_REGULATOR_ENABLE_BIT] & ~pwr_hold;
		loop_regulator_a_enable_out = power_enable_ctrl_r[`SFS_EN_LDO_A_BIT] & ~pwr_hold;
		loop_regulator_b_enable_out = power_enable_ctrl_r[`SFS_EN_LDO_B_BIT] & ~pwr_hold;
		digital_regulator_enable_out = power_enable_ctrl_r[`SFS_DIGITAL_REGULATOR_ENABLE_BIT] & ~pwr_hold;
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	chk_settle_reload: assert property (
		wr_freq && timed_mode && !reg_reset |=> cnt_r == $past(cnt_load))
		else $error("settle count not loaded on frequency write");
	chk_settle_tick: assert property (
		pd_tick && timed_mode && cnt_r > 1 && !word_load |=> cnt_r == $past(cnt_r) - 1)
		else $error("settle count did not step on detector tick");
	chk_untimed_idle: assert property (!timed_mode |-> cnt_r == '0 || $past(timed_mode))
		else $error("settle count running in untimed mode");
	chk_pin_grounded: assert property (
		state_r == SFS_SETTLE && timed_mode |=> settle_pin_oe_out && !settle_pin_out)
		else $error("settle pin not grounded while settling");
	chk_pin_high_code: assert property (
		settle_timeout_count == `SFS_TOC_HIGH ##1 settle_timeout_count == `SFS_TOC_HIGH |-> settle_pin_out && settle_pin_oe_out)
		else $error("settle pin not high for code three");
	chk_pump_select: assert property (
		##1 !settling && $stable(pump_current) |=> pump_mult_out == {1'b0, $past(pump_current)} + 5'h01)
		else $error("normal pump current not applied in steady state");
	chk_power_down: assert property (
		reg_reset |=> ##1 !pll_power_out && !digital_regulator_enable_out)
		else $error("power enables not cleared by register reset");
	chk_integer_mask: assert property (
		int_mode |=> mod_reset_out && num_hi_out == 10'h000)
		else $error("integer mode did not mask fraction");
	chk_fdm_mask: assert property (!extended_fraction_mode |=> den_hi_out == 10'h000)
		else $error("upper denominator bits not ignored");
	chk_order_decode: assert property (
		order_code == `SFS_ORDER_THIRD |=> mod_order_out == 3'h3)
		else $error("third order code decoded wrongly");

	cov_settle_run: cover property (wr_freq && timed_mode ##1 state_r == SFS_SETTLE);
	cov_settle_done: cover property (state_r == SFS_SETTLE ##1 state_r == SFS_STEADY);
	cov_reg_reset: cover property (reg_reset);
	cov_settle_restart: cover property (state_r == SFS_SETTLE && wr_freq);

endmodule : sfs_synth_config_fast_settle_ctrl

/* verif/sfs_host_model.sv */
// host controller model driving the three-wire programming link
`timescale 1ns/1ns
module sfs_host_model (
	output logic ser_clk_out,
	output logic ser_data_out,
	output logic ser_latch_out
);
	initial begin
		ser_clk_out = 1'b0;
		ser_data_out = 1'b0;
		ser_latch_out = 1'b0;
	end
	// ==========================================================
	// word shifting, link clock runs only inside a frame
	task automatic shift(input logic [3:0] addr, input logic [23:0] data);
		logic [27:0] word;
		word = {data, addr};
		// link edges kept off the core clock edges
		#7;
		for (int i = 27; i >= 0; i--) begin
			ser_data_out = word[i];
			#80 ser_clk_out = 1'b1;
			#80 ser_clk_out = 1'b0;
		end
		// released line shows the inverse of the last bit
		ser_data_out = ~word[0];
	endtask : shift
	// ==========================================================
	// latch pulse, link clock held still around it
	task automatic latch();
		#40 ser_latch_out = 1'b1;
		#40 ser_latch_out = 1'b0;
		#80;
	endtask : latch
endmodule : sfs_host_model

/* verif/testbench.sv */
// self-checking bench of the synthesizer configuration and fast-settle control
`timescale 1ns/1ns
`include "sfs_cfg.svh"
module testbench;
	import sfs_pkg::*;
	typedef struct {logic [3:0] a; logic [23:0] d; int g; logic [31:0] e;} sfs_row_t;
	logic clk_in, srst_in, pd_clk_in;
	logic ser_clk, ser_data, ser_latch;
	logic [2:0] mod_order;
	logic mod_reset, dither_weak, dither_strong, output_halve;
	logic settle_pin, settle_pin_oe, settle_active;
	logic [9:0] num_hi, den_hi;
	logic [4:0] pump_mult;
	logic [5:0] res_a, res_b;
	logic [7:0] cap_a, cap_b;
	wire [6:0] pwr;
	int error_cnt = 0;
	int comparisons = 0;
	int cap_a_pf [8] = '{50, 50, 50, 100, 150, 100, 50, 50};
	int cap_b_pf [8] = '{50, 100, 150, 50, 50, 100, 150, 150};
	logic [31:0] filt_exp;
	sfs_row_t rows [15] = '{
		'{4'h1, 24'h001555, 3, 32'h06},
		'{4'h3, 24'h000000, 0, 32'h44},
		'{4'h3, 24'h00a800, 0, 32'h23},
		'{4'h3, 24'h003c00, 0, 32'h30},
		'{4'h3, 24'h003400, 0, 32'h08},
		'{4'h3, 24'h0042aa, 1, 32'h556aa},
		'{4'h3, 24'h0002aa, 1, 32'h0},
		'{4'h3, 24'h0046aa, 1, 32'h0},
		'{4'h4, 24'h024000, 3, 32'h06},
		'{4'h4, 24'h024001, 3, 32'haa},
		'{4'h4, 24'h024002, 3, 32'h86},
		'{4'h4, 24'h024003, 3, 32'hc6},
		'{4'h0, 24'h000000, 3, 32'hc6},
		'{4'h5, 24'h000055, 4, 32'h55},
		'{4'h5, 24'h00002a, 4, 32'h2a}
	};

	sfs_host_model host (
		.ser_clk_out(ser_clk),
		.ser_data_out(ser_data),
		.ser_latch_out(ser_latch)
	);

	sfs_synth_config_fast_settle_ctrl dut (
		.clk_in(clk_in), .srst_in(srst_in), .ser_clk_in(ser_clk), .ser_data_in(ser_data),
		.ser_latch_in(ser_latch), .pd_clk_in(pd_clk_in), .mod_order_out(mod_order),
		.mod_reset_out(mod_reset), .dither_weak_out(dither_weak),
		.dither_strong_out(dither_strong), .num_hi_out(num_hi), .den_hi_out(den_hi),
		.output_halve_out(output_halve), .settle_pin_out(settle_pin),
		.settle_pin_oe_out(settle_pin_oe), .settle_active_out(settle_active),
		.pump_mult_out(pump_mult), .res_a_kohm_out(res_a), .res_b_kohm_out(res_b),
		.cap_a_pf_out(cap_a), .cap_b_pf_out(cap_b), .pll_power_out(pwr[0]),
		.osc_core_power_enable_out(pwr[1]), .ref_inverter_power_enable_out(pwr[2]),
		.osc_regulator_enable_out(pwr[3]), .loop_regulator_a_enable_out(pwr[4]),
		.loop_regulator_b_enable_out(pwr[5]), .digital_regulator_enable_out(pwr[6])
	);

	initial clk_in = 1'b0;
	always #5 clk_in = ~clk_in;

	// ==========================================================
	// helpers
	function automatic logic [31:0] grp(input int g);
		case (g)
			0: grp = {25'h0, mod_order, mod_reset, dither_weak, dither_strong, output_halve};
			1: grp = {12'h0, num_hi, den_hi};
			2: grp = {4'h0, res_a, res_b, cap_a, cap_b};
			3: grp = {24'h0, settle_pin_oe, settle_pin & settle_pin_oe, settle_active, pump_mult};
			default: grp = {25'h0, pwr};
		endcase
	endfunction : grp

	task automatic check(input int g, input logic [31:0] exp);
		logic [31:0] got;
		got = grp(g);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [3:0] a, input logic [23:0] d);
		@(negedge clk_in);
		host.shift(a, d);
		host.latch();
	endtask : wr

	task automatic pd_pulse(input int n);
		repeat (n) begin
			@(negedge clk_in);
			pd_clk_in = 1'b1;
			repeat (4) @(negedge clk_in);
			pd_clk_in = 1'b0;
			repeat (4) @(negedge clk_in);
		end
	endtask : pd_pulse

	task automatic final_report();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	initial begin
		#500_000;
		error_cnt++;
		final_report();
	end

	// ==========================================================
	// main sequence
	initial begin
		srst_in = 1'b1;
		pd_clk_in = 1'b0;
		repeat (2) @(negedge clk_in);
		srst_in = 1'b0;
		repeat (2) @(negedge clk_in);
		check(4, 32'h0);
		check(3, 32'h01);
		filt_exp = {4'h0, 6'd10, 6'd10, 8'd50, 8'd50};
		check(2, filt_exp);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			check(rows[i].g, rows[i].e);
		end
		for (int k = 0; k < 8; k++) begin
			@(negedge clk_in);
			host.shift(4'h6, 24'(k | (((k + 1) % 4) << 3) | ((k % 4) << 5) |
				(((k + 2) % 4) << 7) | ((3 - k % 4) << 9)));
			check(2, filt_exp);
			host.latch();
			filt_exp = {4'h0, 6'(10 * (k % 4 + 1)), 6'(10 * (4 - k % 4)),
				8'(cap_a_pf[k]), 8'(cap_b_pf[k])};
			check(2, filt_exp);
		end
		foreach (rows[i]) begin
			if (i < 3) begin
				wr(4'(i * 5 + 2), 24'hffffff);
				check(2, filt_exp);
			end
		end
		// timed fast settle at the smallest timed count
		wr(4'h6, 24'h0001b0);
		wr(4'h4, 24'h024004);
		check(3, 32'h06);
		wr(4'h0, 24'h000000);
		check(3, 32'haa);
		check(2, {4'h0, 6'd30, 6'd40, 8'd50, 8'd50});
		pd_pulse(7);
		check(3, 32'haa);
		pd_pulse(1);
		repeat (6) @(negedge clk_in);
		check(3, 32'h06);
		check(2, {4'h0, 6'd20, 6'd10, 8'd50, 8'd50});
		// reload before expiry restarts the count
		wr(4'h0, 24'h000000);
		pd_pulse(5);
		wr(4'h0, 24'h000000);
		pd_pulse(7);
		check(3, 32'haa);
		pd_pulse(1);
		repeat (6) @(negedge clk_in);
		check(3, 32'h06);
		// register reset bit and three-write start-up
		wr(4'h5, 24'h0000ff);
		check(4, 32'h0);
		check(3, 32'h01);
		check(2, {4'h0, 6'd10, 6'd10, 8'd50, 8'd50});
		wr(4'h5, 24'h000000);
		check(4, 32'h0);
		wr(4'h5, 24'h00007f);
		check(4, 32'h7f);
		check(3, 32'h01);
		// mid-run synchronous reset returns every default
		wr(4'h3, 24'h00a800);
		check(0, 32'h23);
		@(negedge clk_in);
		srst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		srst_in = 1'b0;
		repeat (3) @(negedge clk_in);
		check(0, 32'h44);
		check(4, 32'h0);
		check(3, 32'h01);
		final_report();
	end
endmodule : testbench
